// ==== design/cache_irq_pkg.sv ====
// Purpose: shared constants and carriers for the cache interrupt status block
// Assumes: 32-bit APB data, 12-bit byte offsets, one clock domain
// Notes:   source bit positions are common to both security domains
package cache_irq_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_SEC_PEND = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_SEC_CLR = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_SEC_MASK = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_SEC_FADDR = 12'h10C;
    localparam logic [ADDR_W-1:0] OFF_SEC_FORG = 12'h110;
    localparam logic [ADDR_W-1:0] OFF_NS_PEND = 12'h140;
    localparam logic [ADDR_W-1:0] OFF_NS_CLR = 12'h144;
    localparam logic [ADDR_W-1:0] OFF_NS_MASK = 12'h148;
    localparam logic [ADDR_W-1:0] OFF_NS_FADDR = 12'h14C;
    localparam logic [ADDR_W-1:0] OFF_NS_FORG = 12'h150;

    // ------------------------------------------------------------
    // source bit positions and field layout
    // ------------------------------------------------------------
    localparam int SRC_W = 8;
    localparam int B_XOM = 7;
    localparam int B_NSSAT = 6;
    localparam int B_SSAT = 5;
    localparam int B_TRERR = 4;
    localparam int B_DROP = 3;
    localparam int B_DONE = 2;
    localparam int B_BYP = 1;
    localparam int B_OPER = 0;
    localparam logic [SRC_W-1:0] SEC_VALID = 8'hFF;
    localparam logic [SRC_W-1:0] NS_VALID = 8'hDC;
    localparam logic [SRC_W-1:0] FLAG_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // fault origin codes
    localparam logic [1:0] ORG_EARLY_WR = 2'h0;
    localparam logic [1:0] ORG_EVICT_WB = 2'h1;
    localparam logic [1:0] ORG_LINEFILL = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic nonsecure;
        logic [1:0] origin;
        logic [7:0] master;
        logic [31:0] addr;
    } faultReport_t;

    typedef struct packed {
        logic [1:0] origin;
        logic [7:0] master;
        logic [31:0] addr;
    } faultInfo_t;

    typedef enum logic [0:0] {
        PH_IDLE,
        PH_REPLY
    } apbPhase_t;

endpackage

// ==== design/irq_flag_bank.sv ====
// Purpose: sticky source flags, enable mask and interrupt line of one domain
// Assumes: set and clear strobes come from logic on the same clock
// Notes:   a set in the cycle of a clear wins, so no event is lost
`timescale 1ns/1ps
module irq_flag_bank #(
    parameter logic [cache_irq_pkg::SRC_W-1:0] VALID = cache_irq_pkg::SEC_VALID
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // source events and software strobes
    input wire logic [cache_irq_pkg::SRC_W-1:0] setEvt,
    input wire logic clrWr,
    input wire logic maskWr,
    input wire logic [cache_irq_pkg::SRC_W-1:0] wrData,
    // state
    output logic [cache_irq_pkg::SRC_W-1:0] pending,
    output logic [cache_irq_pkg::SRC_W-1:0] mask,
    output logic irq
);
    import cache_irq_pkg::*;

    logic [SRC_W-1:0] clrBits;

    // write-one-to-clear; zero bits leave a flag alone
    assign clrBits = clrWr ? wrData : FLAG_RST;

    // flags: set beats clear, reserved bits never stick
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pending <= FLAG_RST;
        end else begin
            pending <= ((pending & ~clrBits) | setEvt) & VALID;
        end
    end

    // enable mask, only implemented bits hold a value
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask <= FLAG_RST;
        end else if (maskWr) begin
            mask <= wrData & VALID;
        end
    end

    // registered line: stays up while any enabled flag is pending
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pending & mask);
        end
    end

endmodule

// ==== design/fault_info_capture.sv ====
// Purpose: holds address, master and origin of the latest bus fault
// Assumes: capture is a one-cycle strobe on the cache clock
// Notes:   a newer fault overwrites an older one before software reads it
`timescale 1ns/1ps
module fault_info_capture (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // fault report
    input wire logic capture,
    input wire cache_irq_pkg::faultReport_t report,
    // held details
    output cache_irq_pkg::faultInfo_t info
);
    import cache_irq_pkg::*;

    // latest fault wins; software sees the most recent cause
    always_ff @(posedge clk) begin
        if (!rstn) begin
            info <= '0;
        end else if (capture) begin
            info.addr <= report.addr;
            info.master <= report.master;
            info.origin <= report.origin;
        end
    end

endmodule

// ==== design/cache_irq_status_logic.sv ====
// Purpose: Secure and Non-secure interrupt sources of the bus cache
// Assumes: events and fault reports are one-cycle pulses on clk
// Notes:   APB slave answers with one wait state; unmapped gives pslverr
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

// Operation
// - write-only Secure clear at 0x104, bits 7..0 clear the eight sources
// - Secure clear bits 3 and 2 clear upkeep events; upper bits read zero
// - Secure enable at 0x108 resets zero; disabled sources never raise Secure line
// - Secure master fault address captured whole in read-only 0x10C
// - Secure fault origin code in bits 9..8 of read-only 0x110
// - linefill error not passed on invalidates the fetched line
// - Secure faulting master id captured in bits 7..0 of 0x110
// - Non-secure bit 7 flags execute-only violation; status at 0x140
// - Non-secure bit 6 flags counter saturation when stats not permitted
// - Non-secure bit 4 flags master fault and stores its details
// - Non-secure bit 3 flags a dropped upkeep request
// - Non-secure bit 2 flags upkeep finished; bits 5,1,0 read zero
// - Non-secure clear at 0x144 clears bits 7,6,4,3,2
// - Non-secure enable at 0x148 gates its line per source
// - Non-secure fault address captured whole in 0x14C
// - Non-secure fault origin in bits 9..8 of 0x150
// - Non-secure faulting master id in bits 7..0 of 0x150
// - Secure status at 0x100; bit 4 flags bus or execute-only fault
// - Secure bits 0 and 1 flag operational and bypassed
module cache_irq_status_logic (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cache_irq_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // events from the cache core
    input wire logic [cache_irq_pkg::SRC_W-1:0] secEvt,
    input wire logic [cache_irq_pkg::SRC_W-1:0] nsEvt,
    input wire logic ns_stats_permitted,
    input wire cache_irq_pkg::faultReport_t faultIn,
    // line drop request to the cache core
    output logic lineInvalidate,
    output logic [31:0] lineInvalidateAddr,
    // interrupt lines
    output logic irqSecure,
    output logic irqNonsecure
);
    import cache_irq_pkg::*;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    apbPhase_t phase_q;
    logic launch;
    logic commit;
    logic hit;
    logic [31:0] rdMux;
    logic wrSecClr;
    logic wrSecMask;
    logic wrNsClr;
    logic wrNsMask;

    // a request is taken on its first access cycle, done one cycle later
    assign launch = psel && penable && (phase_q == PH_IDLE);
    assign commit = psel && penable && (phase_q == PH_REPLY) && pwrite && hit;

    // one wait state gives the read mux a full cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_q <= PH_IDLE;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (launch) begin
                        phase_q <= PH_REPLY;
                    end
                end
                PH_REPLY: begin
                    phase_q <= PH_IDLE;
                end
                default: begin
                    phase_q <= PH_IDLE;
                end
            endcase
        end
    end

    // answer: pready, read data and error all leave flip-flops
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= WORD_RST;
        end else begin
            pready <= launch;
            pslverr <= launch && !hit;
            if (launch) begin
                prdata <= pwrite ? WORD_RST : rdMux;
            end
        end
    end

    // write strobes, only at the completing edge
    assign wrSecClr = commit && (paddr == OFF_SEC_CLR);
    assign wrSecMask = commit && (paddr == OFF_SEC_MASK);
    assign wrNsClr = commit && (paddr == OFF_NS_CLR);
    assign wrNsMask = commit && (paddr == OFF_NS_MASK);

    // ------------------------------------------------------------
    // event routing
    // ------------------------------------------------------------
    logic secFault;
    logic nsFault;
    logic [SRC_W-1:0] secSet;
    logic [SRC_W-1:0] nsSet;

    assign secFault = faultIn.valid && !faultIn.nonsecure;
    assign nsFault = faultIn.valid && faultIn.nonsecure;

    // saturation only reaches software that cannot read the counters
    always_comb begin
        secSet = secEvt;
        secSet[B_NSSAT] = secEvt[B_NSSAT] && !ns_stats_permitted;
        secSet[B_TRERR] = secEvt[B_TRERR] || secFault || secEvt[B_XOM];
        nsSet = nsEvt & NS_VALID;
        nsSet[B_NSSAT] = nsEvt[B_NSSAT] && !ns_stats_permitted;
        nsSet[B_TRERR] = nsEvt[B_TRERR] || nsFault;
    end

    // ------------------------------------------------------------
    // flag banks and fault details
    // ------------------------------------------------------------
    logic [SRC_W-1:0] secPend;
    logic [SRC_W-1:0] secMask;
    logic [SRC_W-1:0] nsPend;
    logic [SRC_W-1:0] nsMask;
    faultInfo_t secInfo;
    faultInfo_t nsInfo;

    // secure bank: all eight sources implemented
    irq_flag_bank #(
        .VALID(SEC_VALID)
    ) u_secBank (
        .clk(clk),
        .rstn(rstn),
        .setEvt(secSet),
        .clrWr(wrSecClr),
        .maskWr(wrSecMask),
        .wrData(pwdata[SRC_W-1:0]),
        .pending(secPend),
        .mask(secMask),
        .irq(irqSecure)
    );

    // non-secure bank: bits 5, 1 and 0 stay zero
    irq_flag_bank #(
        .VALID(NS_VALID)
    ) u_nsBank (
        .clk(clk),
        .rstn(rstn),
        .setEvt(nsSet),
        .clrWr(wrNsClr),
        .maskWr(wrNsMask),
        .wrData(pwdata[SRC_W-1:0]),
        .pending(nsPend),
        .mask(nsMask),
        .irq(irqNonsecure)
    );

    // each domain keeps the details of its own latest fault
    fault_info_capture u_secInfo (
        .clk(clk),
        .rstn(rstn),
        .capture(secFault),
        .report(faultIn),
        .info(secInfo)
    );

    fault_info_capture u_nsInfo (
        .clk(clk),
        .rstn(rstn),
        .capture(nsFault),
        .report(faultIn),
        .info(nsInfo)
    );

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    // write-only clears read as zero; unknown offsets flag an error
    always_comb begin
        rdMux = WORD_RST;
        hit = 1'b1;
        case (paddr)
            OFF_SEC_PEND: rdMux = 32'(secPend);
            OFF_SEC_CLR: rdMux = WORD_RST;
            OFF_SEC_MASK: rdMux = 32'(secMask);
            OFF_SEC_FADDR: rdMux = secInfo.addr;
            OFF_SEC_FORG: rdMux = 32'({secInfo.origin, secInfo.master});
            OFF_NS_PEND: rdMux = 32'(nsPend);
            OFF_NS_CLR: rdMux = WORD_RST;
            OFF_NS_MASK: rdMux = 32'(nsMask);
            OFF_NS_FADDR: rdMux = nsInfo.addr;
            OFF_NS_FORG: rdMux = 32'({nsInfo.origin, nsInfo.master});
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // linefill fault: drop the fetched line
    // ------------------------------------------------------------
    // writes already merged into that line are lost with it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lineInvalidate <= 1'b0;
            lineInvalidateAddr <= WORD_RST;
        end else begin
            lineInvalidate <= faultIn.valid && (faultIn.origin == ORG_LINEFILL);
            if (faultIn.valid && (faultIn.origin == ORG_LINEFILL)) begin
                lineInvalidateAddr <= faultIn.addr;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_launch;
        psel && penable && !pready;
    endsequence

    sequence s_reply;
        pready ##1 !pready;
    endsequence

    property p_apb_answer;
        s_launch |=> s_reply;
    endproperty

    a_apb_reply_timing: assert property (p_apb_answer)
        else $error("apb answer not exactly one wait state");

    a_sec_clear_works: assert property (
        wrSecClr |=> ((secPend & $past(pwdata[SRC_W-1:0]) & ~$past(secSet)) == FLAG_RST))
        else $error("secure flag survived its clear");

    a_sec_clear_zero: assert property (
        s_launch && !pwrite && (paddr == OFF_SEC_CLR) |=> (prdata == WORD_RST))
        else $error("secure clear register read not zero");

    a_zero_keeps_flag: assert property (
        wrSecClr && !pwdata[B_DROP] && secPend[B_DROP] |=> secPend[B_DROP])
        else $error("writing zero cleared a flag");

    a_sec_masked_quiet: assert property (
        ((secPend & secMask) == FLAG_RST) |=> !irqSecure)
        else $error("secure line up with nothing enabled");

    a_sec_fault_info: assert property (
        secFault |=> secPend[B_TRERR] && (secInfo.addr == $past(faultIn.addr))
            && (secInfo.master == $past(faultIn.master))
            && (secInfo.origin == $past(faultIn.origin)))
        else $error("secure fault details not captured");

    a_line_drop: assert property (
        faultIn.valid && (faultIn.origin == ORG_LINEFILL)
            |=> lineInvalidate && (lineInvalidateAddr == $past(faultIn.addr)) ##1 !lineInvalidate
            || $past(faultIn.valid, 1))
        else $error("linefill fault did not drop the line");

    a_ns_xom_flag: assert property (
        nsEvt[B_XOM] || nsEvt[B_DROP] |=> (nsPend[B_XOM] || !$past(nsEvt[B_XOM]))
            && (nsPend[B_DROP] || !$past(nsEvt[B_DROP])))
        else $error("non-secure violation or drop flag missed");

    a_ns_sat_gate: assert property (
        nsEvt[B_NSSAT] && !ns_stats_permitted |=> nsPend[B_NSSAT])
        else $error("non-secure saturation flag missed");

    a_ns_fault_info: assert property (
        nsFault |=> nsPend[B_TRERR] && (nsInfo.addr == $past(faultIn.addr))
            && (nsInfo.master == $past(faultIn.master))
            && (nsInfo.origin == $past(faultIn.origin)))
        else $error("non-secure fault details not captured");

    a_ns_reserved_zero: assert property (
        (nsPend & ~NS_VALID) == FLAG_RST)
        else $error("non-secure reserved status bit set");

    a_ns_clear_works: assert property (
        wrNsClr |=> ((nsPend & $past(pwdata[SRC_W-1:0]) & ~$past(nsSet)) == FLAG_RST))
        else $error("non-secure flag survived its clear");

    a_ns_masked_quiet: assert property (
        ((nsPend & nsMask) == FLAG_RST) |=> !irqNonsecure)
        else $error("non-secure line up with nothing enabled");

    a_sec_state_flags: assert property (
        secEvt[B_OPER] && secEvt[B_BYP] |=> secPend[B_OPER] && secPend[B_BYP])
        else $error("operational or bypass flag missed");

    a_irq_held: assert property (
        ((secPend & secMask) != FLAG_RST) |=> irqSecure)
        else $error("secure line low with enabled flag pending");

endmodule

// ==== test/cache_core_model.sv ====
// Purpose: behavioural cache core that raises source events and bus faults
// Assumes: every pulse lasts exactly one clk cycle, driven just after an edge
// Notes:   idle fault fields show the inverse of the last report, never stale data
`timescale 1ns/1ps
module cache_core_model
    import cache_irq_pkg::*;
(
    // clock
    input wire logic clk,
    // events and fault report towards the block
    output logic [SRC_W-1:0] secEvt,
    output logic [SRC_W-1:0] nsEvt,
    output faultReport_t faultIn
);
    // ----------------------------------------------------------------
    // event and fault pulse
    // ----------------------------------------------------------------
    initial begin
        secEvt = FLAG_RST;
        nsEvt = FLAG_RST;
        faultIn = '0;
    end

    // one-cycle pulse; fields are scrambled afterwards so a stale capture shows up
    task automatic send(input logic [SRC_W-1:0] s, input logic [SRC_W-1:0] n,
                        input faultReport_t f);
        faultReport_t idle;
        idle = ~f;
        idle.valid = 1'b0;
        @(posedge clk);
        secEvt <= s;
        nsEvt <= n;
        faultIn <= f;
        @(posedge clk);
        secEvt <= FLAG_RST;
        nsEvt <= FLAG_RST;
        faultIn <= idle;
    endtask
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for the cache interrupt status block
// Assumes: APB slave answers within a few cycles; events come from the core model
// Notes:   expectations are literal values worked out by hand, not read back
`timescale 1ns/1ps
module tb;
    import cache_irq_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic nsStatsOk = 1'b0;
    logic [SRC_W-1:0] secEvt;
    logic [SRC_W-1:0] nsEvt;
    faultReport_t faultIn;
    logic lineInvalidate;
    logic [31:0] lineInvalidateAddr;
    logic irqSecure;
    logic irqNonsecure;
    logic [31:0] lastData;
    logic lastErr;
    logic [7:0] exp;
    logic [31:0] ad;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [ADDR_W-1:0] offs [10] = '{OFF_SEC_PEND, OFF_SEC_CLR, OFF_SEC_MASK, OFF_SEC_FADDR,
        OFF_SEC_FORG, OFF_NS_PEND, OFF_NS_CLR, OFF_NS_MASK, OFF_NS_FADDR, OFF_NS_FORG};
    int nsBits [5] = '{7, 6, 4, 3, 2};
    localparam faultReport_t NOFAULT = '0;

    always #12.5 clk = ~clk;

    cache_irq_status_logic dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .secEvt(secEvt), .nsEvt(nsEvt), .ns_stats_permitted(nsStatsOk),
        .faultIn(faultIn), .lineInvalidate(lineInvalidate),
        .lineInvalidateAddr(lineInvalidateAddr), .irqSecure(irqSecure),
        .irqNonsecure(irqNonsecure));

    cache_core_model core (.clk(clk), .secEvt(secEvt), .nsEvt(nsEvt), .faultIn(faultIn));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, want, got);
        end
    endtask

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        lastData = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(nm, lastData, want);
    endtask

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        foreach (offs[i]) rdchk("resetValue", offs[i], 32'h0000_0000);
        // every Secure source pending while all enables are off
        core.send(8'hFF, 8'h00, NOFAULT);
        rdchk("secPend", OFF_SEC_PEND, 32'h0000_00FF);
        chk("irqSecOff", {31'h0, irqSecure}, 32'h0);
        wr(OFF_SEC_CLR, 32'hFFFF_FF00);
        rdchk("secClrRead", OFF_SEC_CLR, 32'h0000_0000);
        rdchk("secPendKeep", OFF_SEC_PEND, 32'h0000_00FF);
        wr(OFF_SEC_MASK, 32'hFFFF_FFFF);
        rdchk("secMask", OFF_SEC_MASK, 32'h0000_00FF);
        exp = 8'hFF;
        for (int i = 7; i >= 0; i--) begin
            chk("irqSec", {31'h0, irqSecure}, {31'h0, exp != 8'h00});
            wr(OFF_SEC_CLR, 32'h1 << i);
            exp[i] = 1'b0;
            rdchk("secClrBit", OFF_SEC_PEND, {24'h0, exp});
        end
        chk("irqSecDone", {31'h0, irqSecure}, 32'h0);
        // only operational enabled, so a bypass event must stay silent
        wr(OFF_SEC_MASK, 32'h0000_0001);
        core.send(8'h02, 8'h00, NOFAULT);
        repeat (3) @(posedge clk);
        chk("irqSecPart", {31'h0, irqSecure}, 32'h0);
        wr(OFF_SEC_CLR, 32'h0000_0002);
        // Non-secure side with its five implemented sources
        wr(OFF_NS_MASK, 32'hFFFF_FFFF);
        rdchk("nsMask", OFF_NS_MASK, 32'h0000_00DC);
        core.send(8'h00, 8'hFF, NOFAULT);
        rdchk("nsPend", OFF_NS_PEND, 32'h0000_00DC);
        exp = 8'hDC;
        foreach (nsBits[i]) begin
            chk("irqNs", {31'h0, irqNonsecure}, 32'h1);
            wr(OFF_NS_CLR, 32'h1 << nsBits[i]);
            exp[nsBits[i]] = 1'b0;
            rdchk("nsClrBit", OFF_NS_PEND, {24'h0, exp});
        end
        chk("irqNsDone", {31'h0, irqNonsecure}, 32'h0);
        wr(OFF_NS_PEND, 32'hFFFF_FFFF);
        rdchk("nsPendRo", OFF_NS_PEND, 32'h0000_0000);
        // saturation is flagged only while stats access is not permitted
        nsStatsOk <= 1'b1;
        core.send(8'h00, 8'h40, NOFAULT);
        rdchk("nsSatGated", OFF_NS_PEND, 32'h0000_0000);
        nsStatsOk <= 1'b0;
        core.send(8'h00, 8'h40, NOFAULT);
        rdchk("nsSat", OFF_NS_PEND, 32'h0000_0040);
        wr(OFF_NS_CLR, 32'h0000_0040);
        // bus faults of every origin in both domains
        for (int ns = 0; ns < 2; ns++) begin
            for (int org = 0; org < 3; org++) begin
                ad = 32'hC35A_0F00 ^ (ns << 20) ^ (org << 4);
                core.send(8'h00, 8'h00, '{1'b1, ns[0], org[1:0], 8'hA0 + 8'(org), ad});
                #1;
                chk("lineInv", {31'h0, lineInvalidate}, {31'h0, org == 2});
                if (org == 2)
                    chk("lineInvAddr", lineInvalidateAddr, ad);
                if (ns == 0) begin
                    rdchk("secAddr", OFF_SEC_FADDR, ad);
                    rdchk("secOrg", OFF_SEC_FORG, {22'h0, org[1:0], 8'hA0 + 8'(org)});
                    rdchk("secErr", OFF_SEC_PEND, 32'h0000_0010);
                    wr(OFF_SEC_CLR, 32'h0000_0010);
                end else begin
                    rdchk("nsAddr", OFF_NS_FADDR, ad);
                    rdchk("nsOrg", OFF_NS_FORG, {22'h0, org[1:0], 8'hA0 + 8'(org)});
                    rdchk("nsErr", OFF_NS_PEND, 32'h0000_0010);
                    wr(OFF_NS_CLR, 32'h0000_0010);
                end
            end
        end
        // unmapped offset is refused with an error and zero data
        apb(1'b0, 12'h1FC, 32'h0);
        chk("unmapErr", {31'h0, lastErr}, 32'h1);
        chk("unmapData", lastData, 32'h0);
        stop_test();
    end
endmodule
